// [cpu_exec_chk.sv]
/*
 Port checker for cpu_instr_exec_subset.
 Assumes a master that holds each request until waitrequest is low.
*/
`timescale 1ns/10ps

module cpu_exec_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Bus
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Flags
	input wire logic zeroFlag,
	input wire logic powerdownFlag,
	input wire logic watchdogExpiryFlag
);
	logic busy;
	logic taken;
	logic isIns;
	logic [5:0] opc;

	// A held request must not count again while its answer is pending
	assign taken = (read || write) && !busy;
	assign isIns = taken && write && address == cpu_exec_pkg::REG_INSTR;
	assign opc = writedata[13:8];

	// Pending answer tracker
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			busy <= 1'h0;
		else if (taken)
			busy <= 1'h1;
		else if (!waitrequest)
			busy <= 1'h0;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_rst_val;
		$fell(sys_rst) |-> waitrequest && powerdownFlag && watchdogExpiryFlag
			&& !zeroFlag;
	endproperty
	property p_ack_one;
		!waitrequest |=> waitrequest;
	endproperty
	property p_powerdown_hold;
		!$fell(powerdownFlag);
	endproperty
	property p_kick;
		isIns && writedata[13:0] == cpu_exec_pkg::OP_KICK
			|-> ##2 !waitrequest && watchdogExpiryFlag && powerdownFlag;
	endproperty
	property p_call;
		isIns && writedata[13:11] == cpu_exec_pkg::OP_CALL_TOP
			|-> waitrequest[*3] ##1 !waitrequest && zeroFlag == $past(zeroFlag, 3);
	endproperty
	property p_clear;
		isIns && opc == cpu_exec_pkg::OP_CLEAR |-> ##2 zeroFlag;
	endproperty
	property p_one_cyc;
		isIns && (opc == cpu_exec_pkg::OP_INVERT || opc == cpu_exec_pkg::OP_DEC)
			|-> waitrequest[*2] ##1 !waitrequest;
	endproperty
	property p_skip_flags;
		isIns && opc == cpu_exec_pkg::OP_DECSKIP
			|-> ##2 zeroFlag == $past(zeroFlag, 2);
	endproperty
	property p_stat_rd;
		taken && read && address == cpu_exec_pkg::REG_STATUS |=> !waitrequest
			&& readdata[2:0] == {watchdogExpiryFlag, powerdownFlag, zeroFlag};
	endproperty

	a_rst_val: assert property (p_rst_val) else $error("reset values");
	a_ack_one: assert property (p_ack_one) else $error("long ack");
	a_powerdown_hold: assert property (p_powerdown_hold)
		else $error("powerdown fell");
	a_kick: assert property (p_kick) else $error("kick flags");
	a_call: assert property (p_call) else $error("call timing");
	a_clear: assert property (p_clear) else $error("clear zero");
	a_one_cyc: assert property (p_one_cyc) else $error("op timing");
	a_skip_flags: assert property (p_skip_flags) else $error("skip z");
	a_stat_rd: assert property (p_stat_rd) else $error("status read");

	c_call: cover property (p_call);
	c_kick: cover property (p_kick);
	c_skip: cover property (p_skip_flags);
endmodule : cpu_exec_chk

bind cpu_instr_exec_subset cpu_exec_chk u_chk (.clk_sys, .sys_rst, .address,
	.read, .write, .writedata, .readdata, .waitrequest, .zeroFlag,
	.powerdownFlag, .watchdogExpiryFlag);

// [cpu_exec_pkg.sv]
/*
 Constants, types and register map for the instruction execution subset.
 Assumes one 20 MHz system clock and an Avalon-MM master that issues
 one instruction word per write to the instruction register.
*/
// Overview of operation
// - Call pushes current program counter plus one onto the stack top.
// - Call loads literal into bits 10:0, latch bits 4:3 into 12:11.
// - Call takes two instruction cycles and changes no status flag.
// - Watchdog kick resets the watchdog counter to zero.
// - Watchdog kick also clears the watchdog prescaler count.
// - Watchdog kick sets expiry and powerdown flags, nothing else.
// - File zero clears the addressed file register, sets zero flag.
// - Accumulator zero clears accumulator, no operands, sets zero flag.
// - File invert yields the bitwise inverse; only zero flag moves.
// - Destination bit 0 sends result to accumulator, 1 back to the file.
// - Decrement subtracts one, routes by destination, updates zero flag.
// - Decrement-skip keeps flags; zero result skips, taking 2 cycles.
package cpu_exec_pkg;

	// Register byte offsets on the Avalon-MM port
	localparam logic [9:0] REG_INSTR = 10'h000;
	localparam logic [9:0] REG_PC = 10'h004;
	localparam logic [9:0] REG_ACC = 10'h008;
	localparam logic [9:0] REG_STATUS = 10'h00C;
	localparam logic [9:0] REG_LATCH = 10'h010;
	localparam logic [9:0] REG_STACK = 10'h014;
	localparam logic [9:0] REG_WDOG = 10'h018;
	localparam logic [9:0] REG_EXEC = 10'h01C;
	// Address bit that selects the file register window
	localparam int FILE_SEL_BIT = 9;

	// Status register bit positions
	localparam int ZERO_BIT = 0;
	localparam int POWERDOWN_BIT = 1;
	localparam int EXPIRY_BIT = 2;

	// Instruction encodings
	localparam logic [13:0] OP_KICK = 14'h0064;
	localparam logic [2:0] OP_CALL_TOP = 3'h4;
	localparam logic [5:0] OP_CLEAR = 6'h01;
	localparam logic [5:0] OP_INVERT = 6'h09;
	localparam logic [5:0] OP_DEC = 6'h03;
	localparam logic [5:0] OP_DECSKIP = 6'h0B;

	// Field positions
	localparam int LATCH_HI = 4;
	localparam int LATCH_LO = 3;
	localparam int LIT_HI = 10;
	localparam int EXEC_PTR_LO = 4;

	// Reset values, zero byte and program counter steps
	localparam logic [12:0] PC_RST = 13'h0000;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [4:0] LATCH_RST = 5'h00;
	localparam logic [7:0] WDOG_RST = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [12:0] PC_STEP = 13'h0001;
	localparam logic [12:0] PC_SKIP_STEP = 13'h0002;

	// Bus handshake states, Gray along idle-exec-exec-ack
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_EXEC1 = 2'b01,
		ST_EXEC2 = 2'b11,
		ST_ACK = 2'b10
	} bus_state_t;

	// Byte-oriented file instruction layout
	typedef struct packed
	{
		logic [5:0] opcode;
		logic dest;
		logic [6:0] fileAddr;
	} file_instr_t;

endpackage : cpu_exec_pkg

// [cpu_instr_exec_subset.sv]
/*
 Execution core for call, watchdog kick, clears, invert, decrement and
 decrement-skip, with file registers, a return stack and a watchdog.
 Assumes an Avalon-MM master that holds each request until it sees
 waitrequest low, and a synchronous active-high reset.
*/
`timescale 1ns/10ps

module cpu_instr_exec_subset #(
	parameter int STACK_DEPTH = 8,
	parameter int FILE_DEPTH = 128,
	parameter int WD_PRESCALE = 256
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Status flags for observation
	output logic zeroFlag,
	output logic powerdownFlag,
	output logic watchdogExpiryFlag
);

	localparam int PTR_W = $clog2(STACK_DEPTH);
	localparam int PRE_W = $clog2(WD_PRESCALE);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(WD_PRESCALE - 1);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

	cpu_exec_pkg::bus_state_t state;
	cpu_exec_pkg::file_instr_t instr;
	logic [13:0] instrWord;
	logic [12:0] pc;
	logic [7:0] accumulator;
	logic [4:0] program_counter_high_latch;
	logic [12:0] stackMem [STACK_DEPTH];
	logic [PTR_W-1:0] stackPtr;
	logic [7:0] fileMem [FILE_DEPTH];
	logic [PRE_W-1:0] wdPrescale;
	logic [7:0] watchdog_counter;
	logic lastSkipped;

	logic isCall, isKick, isFileZero, isAccZero;
	logic isInvert, isDec, isDecSkip, usesDest, twoCycle;
	logic [7:0] fileVal, result;
	logic resultZero, execNow, busWr, fileHit, wdTick, wdExpire;
	logic [12:0] stack_top;
	logic [31:0] next_readdata;

	// Byte-lane merge so partial writes keep untouched lanes
	function automatic logic [31:0] merge_lanes(
		input logic [31:0] oldVal,
		input logic [31:0] newVal,
		input logic [3:0] be
	);
		logic [31:0] merged;
		merged = oldVal;
		for (int i = 0; i < 4; i++)
			if (be[i])
				merged[8*i +: 8] = newVal[8*i +: 8];
		return merged;
	endfunction : merge_lanes

	// Instruction decode and datapath
	always_comb
	begin
		isCall = instrWord[13:11] == cpu_exec_pkg::OP_CALL_TOP;
		isKick = instrWord == cpu_exec_pkg::OP_KICK;
		isFileZero = instr.opcode == cpu_exec_pkg::OP_CLEAR && instr.dest;
		isAccZero = instr.opcode == cpu_exec_pkg::OP_CLEAR
			&& !instr.dest;
		isInvert = instr.opcode == cpu_exec_pkg::OP_INVERT;
		isDec = instr.opcode == cpu_exec_pkg::OP_DEC;
		isDecSkip = instr.opcode == cpu_exec_pkg::OP_DECSKIP;
		usesDest = isInvert || isDec || isDecSkip;
		fileVal = fileMem[instr.fileAddr];
		if (isInvert)
			result = ~fileVal;
		else if (isDec || isDecSkip)
			result = fileVal - 8'h01;
		else
			result = cpu_exec_pkg::BYTE_ZERO;
		resultZero = result == cpu_exec_pkg::BYTE_ZERO;
		twoCycle = isCall || (isDecSkip && resultZero);
	end

	// Bus strobes and shared values
	assign execNow = state == cpu_exec_pkg::ST_EXEC1;
	assign busWr = state == cpu_exec_pkg::ST_IDLE && write;
	assign fileHit = address[cpu_exec_pkg::FILE_SEL_BIT];
	assign stack_top = stackMem[stackPtr];
	assign wdTick = wdPrescale == PRE_LAST;
	assign wdExpire = wdTick && watchdog_counter == 8'hFF;

	// Read data mux; unmapped offsets read as zero
	always_comb
	begin
		next_readdata = 32'h0000_0000;
		if (fileHit)
			next_readdata = {24'h00_0000, fileMem[address[8:2]]};
		else
			case (address)
				cpu_exec_pkg::REG_INSTR:
					next_readdata = {18'h0_0000, instrWord};
				cpu_exec_pkg::REG_PC:
					next_readdata = {19'h0_0000, pc};
				cpu_exec_pkg::REG_ACC:
					next_readdata = {24'h00_0000, accumulator};
				cpu_exec_pkg::REG_STATUS:
					next_readdata = {29'h0000_0000, watchdogExpiryFlag,
						powerdownFlag, zeroFlag};
				cpu_exec_pkg::REG_LATCH:
					next_readdata = {27'h000_0000, program_counter_high_latch};
				cpu_exec_pkg::REG_STACK:
					next_readdata = {19'h0_0000, stack_top};
				cpu_exec_pkg::REG_WDOG:
					next_readdata = {16'h0000, 8'(wdPrescale), watchdog_counter};
				cpu_exec_pkg::REG_EXEC:
					next_readdata = 32'(stackPtr) << cpu_exec_pkg::EXEC_PTR_LO
						| {31'h0000_0000, lastSkipped};
				default:
					next_readdata = 32'h0000_0000;
			endcase
	end

	// Handshake: waitrequest idles high and drops for one cycle per answer
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state <= cpu_exec_pkg::ST_IDLE;
			waitrequest <= 1'b1;
			readdata <= 32'h0000_0000;
		end
		else
			case (state)
				cpu_exec_pkg::ST_IDLE:
					if (read)
					begin
						readdata <= next_readdata;
						waitrequest <= 1'b0;
						state <= cpu_exec_pkg::ST_ACK;
					end
					else if (write && !fileHit && address == cpu_exec_pkg::REG_INSTR)
						state <= cpu_exec_pkg::ST_EXEC1;
					else if (write)
					begin
						waitrequest <= 1'b0;
						state <= cpu_exec_pkg::ST_ACK;
					end
				cpu_exec_pkg::ST_EXEC1:
					if (twoCycle)
						state <= cpu_exec_pkg::ST_EXEC2;
					else
					begin
						waitrequest <= 1'b0;
						state <= cpu_exec_pkg::ST_ACK;
					end
				cpu_exec_pkg::ST_EXEC2:
				begin
					// Second cycle is the discarded slot, a no-operation
					waitrequest <= 1'b0;
					state <= cpu_exec_pkg::ST_ACK;
				end
				cpu_exec_pkg::ST_ACK:
				begin
					waitrequest <= 1'b1;
					state <= cpu_exec_pkg::ST_IDLE;
				end
				default:
				begin
					waitrequest <= 1'b1;
					state <= cpu_exec_pkg::ST_IDLE;
				end
			endcase
	end

	// Instruction word latched as the write is taken
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			instrWord <= 14'h0000;
			instr <= '0;
		end
		else if (busWr && !fileHit && address == cpu_exec_pkg::REG_INSTR)
		begin
			instrWord <= 14'(merge_lanes(32'(instrWord), writedata, byteenable));
			instr <= cpu_exec_pkg::file_instr_t'(14'(merge_lanes(32'(instrWord),
				writedata, byteenable)));
		end
	end

	// Program counter: call target, skip step or plain step
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			pc <= cpu_exec_pkg::PC_RST;
		else if (execNow && isCall)
			pc <= {program_counter_high_latch[cpu_exec_pkg::LATCH_HI:
				cpu_exec_pkg::LATCH_LO],
				instrWord[cpu_exec_pkg::LIT_HI:0]};
		else if (execNow && isDecSkip && resultZero)
			pc <= pc + cpu_exec_pkg::PC_SKIP_STEP;
		else if (execNow)
			pc <= pc + cpu_exec_pkg::PC_STEP;
		else if (busWr && !fileHit && address == cpu_exec_pkg::REG_PC)
			pc <= 13'(merge_lanes(32'(pc), writedata, byteenable));
	end

	// Return stack; deeper nesting than the depth wraps and overwrites
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			stackPtr <= '0;
			for (int i = 0; i < STACK_DEPTH; i++)
				stackMem[i] <= cpu_exec_pkg::PC_RST;
		end
		else if (execNow && isCall)
		begin
			stackMem[stackPtr + PTR_ONE] <= pc + cpu_exec_pkg::PC_STEP;
			stackPtr <= stackPtr + PTR_ONE;
		end
	end

	// Accumulator
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			accumulator <= cpu_exec_pkg::ACC_RST;
		else if (execNow && isAccZero)
			accumulator <= cpu_exec_pkg::BYTE_ZERO;
		else if (execNow && usesDest && !instr.dest)
			accumulator <= result;
		else if (busWr && !fileHit && address == cpu_exec_pkg::REG_ACC)
			accumulator <= 8'(merge_lanes(32'(accumulator), writedata, byteenable));
	end

	// File registers; left unreset, software initialises them
	always_ff @(posedge clk_sys)
	begin
		if (execNow && isFileZero)
			fileMem[instr.fileAddr] <= cpu_exec_pkg::BYTE_ZERO;
		else if (execNow && usesDest && instr.dest)
			fileMem[instr.fileAddr] <= result;
		else if (busWr && fileHit && byteenable[0])
			fileMem[address[8:2]] <= writedata[7:0];
	end

	// High latch, written only by software
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			program_counter_high_latch <= cpu_exec_pkg::LATCH_RST;
		else if (busWr && !fileHit && address == cpu_exec_pkg::REG_LATCH)
			program_counter_high_latch <= 5'(merge_lanes(
				32'(program_counter_high_latch), writedata, byteenable));
	end

	// Zero flag; call, kick and decrement-skip leave it alone
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			zeroFlag <= 1'b0;
		else if (execNow && (isFileZero || isAccZero))
			zeroFlag <= 1'b1;
		else if (execNow && (isInvert || isDec))
			zeroFlag <= resultZero;
		else if (busWr && !fileHit && address == cpu_exec_pkg::REG_STATUS
			&& byteenable[0])
			zeroFlag <= writedata[cpu_exec_pkg::ZERO_BIT];
	end

	// Watchdog prescaler and counter; kick beats a same-cycle tick
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			wdPrescale <= '0;
			watchdog_counter <= cpu_exec_pkg::WDOG_RST;
		end
		else if (execNow && isKick)
		begin
			wdPrescale <= '0;
			watchdog_counter <= cpu_exec_pkg::WDOG_RST;
		end
		else
		begin
			wdPrescale <= wdTick ? '0 : wdPrescale + PRE_W'(1);
			if (wdTick)
				watchdog_counter <= watchdog_counter + 8'h01;
		end
	end

	// Expiry flag drops on overflow; a kick in the same cycle wins
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			watchdogExpiryFlag <= 1'b1;
			powerdownFlag <= 1'b1;
		end
		else if (execNow && isKick)
		begin
			watchdogExpiryFlag <= 1'b1;
			powerdownFlag <= 1'b1;
		end
		else if (wdExpire)
			watchdogExpiryFlag <= 1'b0;
	end

	// Records whether the last decrement-skip skipped
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			lastSkipped <= 1'b0;
		else if (execNow && isDecSkip)
			lastSkipped <= resultZero;
	end

endmodule : cpu_instr_exec_subset

// [cpu_instr_exec_subset_tb.sv]
/*
 Testbench: reset read, table of byte ops, then call, skip, watchdog and mid-run reset cases.
 Assumes cpu_exec_pkg and the bound port checker.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) \
begin \
	n_tests++; \
	if ((g) !== (e)) \
	begin \
		err_total++; \
		$display("ERROR %s exp %h got %h", nm, e, g); \
	end \
end

module cpu_instr_exec_subset_tb;
	typedef struct packed
	{
		logic [6:0] fa;
		logic [7:0] fv;
		logic [5:0] op;
		logic d;
		logic zin;
		logic [7:0] eAcc;
		logic [7:0] eFile;
		logic ez;
		logic [12:0] step;
	} row_t;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic [9:0] address = 10'h000;
	logic read = 1'h0;
	logic write = 1'h0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic zeroFlag;
	logic powerdownFlag;
	logic watchdogExpiryFlag;
	logic [31:0] rdv;
	int err_total = 0;
	int n_tests = 0;
	int n;
	row_t r;
	// Short opcode names keep the table rows narrow
	localparam logic [5:0] OPZ = cpu_exec_pkg::OP_CLEAR;
	localparam logic [5:0] OPI = cpu_exec_pkg::OP_INVERT;
	localparam logic [5:0] OPD = cpu_exec_pkg::OP_DEC;
	localparam logic [5:0] OPS = cpu_exec_pkg::OP_DECSKIP;
	// Preset file, start zero flag, then expected accumulator, file, zero
	row_t rows [8] = '{
		'{7'h7F, 8'h33, OPZ, 1'h1, 1'h0, 8'h5A, 8'h00, 1'h1, 13'h1},
		'{7'h02, 8'h77, OPZ, 1'h0, 1'h0, 8'h00, 8'h77, 1'h1, 13'h1},
		'{7'h00, 8'hFF, OPI, 1'h0, 1'h0, 8'h00, 8'hFF, 1'h1, 13'h1},
		'{7'h05, 8'h0F, OPI, 1'h1, 1'h1, 8'h5A, 8'hF0, 1'h0, 13'h1},
		'{7'h09, 8'h01, OPD, 1'h1, 1'h0, 8'h5A, 8'h00, 1'h1, 13'h1},
		'{7'h09, 8'h00, OPD, 1'h0, 1'h1, 8'hFF, 8'h00, 1'h0, 13'h1},
		'{7'h03, 8'h01, OPS, 1'h1, 1'h1, 8'h5A, 8'h00, 1'h1, 13'h2},
		'{7'h03, 8'h05, OPS, 1'h0, 1'h0, 8'h04, 8'h05, 1'h0, 13'h1}
	};

	cpu_instr_exec_subset #(.WD_PRESCALE(64)) dut (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hF), .readdata(readdata),
		.waitrequest(waitrequest), .zeroFlag(zeroFlag),
		.powerdownFlag(powerdownFlag), .watchdogExpiryFlag(watchdogExpiryFlag));

	// 20 MHz clock
	always #25 clk_sys = ~clk_sys;

	// Bounded wait for the answer edge; the old value is the sampled one
	task automatic wait_ack;
		int k;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (waitrequest !== 1'h0 && k < 20);
		if (k >= 20)
			err_total++;
	endtask : wait_ack

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		address <= a;
		writedata <= d;
		write <= 1'h1;
		wait_ack();
		write <= 1'h0;
	endtask : wr

	task automatic rd(input logic [9:0] a);
		@(posedge clk_sys);
		address <= a;
		read <= 1'h1;
		wait_ack();
		rdv = readdata;
		read <= 1'h0;
	endtask : rd

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	// Hang guard, well past the expiry wait
	initial
	begin
		repeat (30000) @(posedge clk_sys);
		err_total++;
		end_of_test();
	end

	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'h0;
		rd(cpu_exec_pkg::REG_STATUS);
		`CHK("status", 3'h6, rdv[2:0])
		rd(10'h020);
		`CHK("unmapped", 32'h0, rdv)
		$display("reset test done");
		for (int i = 0; i < 8; i++)
		begin
			r = rows[i];
			wr({1'h1, r.fa, 2'h0}, {24'h0, r.fv});
			wr(cpu_exec_pkg::REG_ACC, 32'h5A);
			wr(cpu_exec_pkg::REG_STATUS, {31'h0, r.zin});
			wr(cpu_exec_pkg::REG_PC, 32'h100);
			wr(cpu_exec_pkg::REG_INSTR, {18'h0, r.op, r.d, r.fa});
			rd(cpu_exec_pkg::REG_ACC);
			`CHK("acc", r.eAcc, rdv[7:0])
			rd({1'h1, r.fa, 2'h0});
			`CHK("file", r.eFile, rdv[7:0])
			`CHK("zero", r.ez, zeroFlag)
			rd(cpu_exec_pkg::REG_PC);
			`CHK("pc", 13'h100 + r.step, rdv[12:0])
			$display("row %0d done", i);
		end
		// Call: latch bits 2:0 must not reach the counter
		wr(cpu_exec_pkg::REG_LATCH, 32'h0F);
		wr(cpu_exec_pkg::REG_PC, 32'h123);
		wr(cpu_exec_pkg::REG_STATUS, 32'h1);
		wr(cpu_exec_pkg::REG_INSTR, {18'h0, cpu_exec_pkg::OP_CALL_TOP, 11'h555});
		rd(cpu_exec_pkg::REG_PC);
		`CHK("call pc", 13'h0D55, rdv[12:0])
		rd(cpu_exec_pkg::REG_STACK);
		`CHK("stack top", 13'h0124, rdv[12:0])
		`CHK("call zero", 1'h1, zeroFlag)
		$display("call test done");
		// Skip record and stack pointer share one read-only word
		wr({1'h1, 7'h10, 2'h0}, 32'h01);
		wr(cpu_exec_pkg::REG_INSTR, {18'h0, OPS, 1'h1, 7'h10});
		rd(cpu_exec_pkg::REG_EXEC);
		`CHK("exec", 7'h11, rdv[6:0])
		rd(cpu_exec_pkg::REG_INSTR);
		`CHK("instr", 14'h0B90, rdv[13:0])
		$display("skip record test done");
		// Kick after the counter has run
		repeat (200) @(posedge clk_sys);
		rd(cpu_exec_pkg::REG_WDOG);
		`CHK("wdog run", 1'h1, rdv[7:0] != 8'h00)
		wr(cpu_exec_pkg::REG_INSTR, {18'h0, cpu_exec_pkg::OP_KICK});
		rd(cpu_exec_pkg::REG_WDOG);
		`CHK("wdog", 8'h00, rdv[7:0])
		`CHK("prescale", 1'h1, rdv[15:8] < 8'h08)
		// Expiry must wait a full 256 x 64 cycles after the kick
		n = 0;
		while (watchdogExpiryFlag !== 1'h0 && n < 17000)
		begin
			@(posedge clk_sys);
			n++;
		end
		`CHK("span", 1'h1, n > 16300 && n < 16385)
		wr(cpu_exec_pkg::REG_INSTR, {18'h0, cpu_exec_pkg::OP_KICK});
		`CHK("expiry", 1'h1, watchdogExpiryFlag)
		`CHK("powerdown", 1'h1, powerdownFlag)
		$display("watchdog test done");
		// Reset in mid-run must return the core, bar its unreset file registers, to its power-up state
		@(posedge clk_sys);
		sys_rst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'h0;
		rd(cpu_exec_pkg::REG_PC);
		`CHK("reset pc", cpu_exec_pkg::PC_RST, rdv[12:0])
		rd(cpu_exec_pkg::REG_STACK);
		`CHK("reset stack", cpu_exec_pkg::PC_RST, rdv[12:0])
		rd(cpu_exec_pkg::REG_LATCH);
		`CHK("reset latch", cpu_exec_pkg::LATCH_RST, rdv[4:0])
		rd(cpu_exec_pkg::REG_STATUS);
		`CHK("reset status", 3'h6, rdv[2:0])
		$display("mid-run reset test done");
		end_of_test();
	end
endmodule : cpu_instr_exec_subset_tb
